// *** rtl/refsel_consts.vh ***
/*
 * Constants for the reference-select and master-configuration register bank:
 * register byte addresses, field positions, reset values and code points.
 * Assumes inclusion by the register bank only.
 */
`ifndef REFSEL_CONSTS_VH
`define REFSEL_CONSTS_VH

// ****************************************************************
// register byte addresses (register index times four)
// ****************************************************************
`define IDX_VALID_LOW      8'h30
`define IDX_VALID_HIGH     8'h31
`define IDX_RESET_LOCK     8'h32
`define IDX_FORCE_REF      8'h33
`define IDX_SYNC_HOLD      8'h34
`define ADDR_VALID_LOW     10'h0c0
`define ADDR_VALID_HIGH    10'h0c4
`define ADDR_RESET_LOCK    10'h0c8
`define ADDR_FORCE_REF     10'h0cc
`define ADDR_SYNC_HOLD     10'h0d0
`define ADDR_STATUS        10'h0d4
`define ADDR_RATE0         10'h0d8
`define ADDR_RATE1         10'h0dc
`define ADDR_RATE2         10'h0e0

// ****************************************************************
// reset values
// ****************************************************************
`define RST_VALID_LOW      8'hbf
`define RST_VALID_HIGH     8'h01
`define RST_RESET_LOCK     8'h20
`define RST_FORCE_REF      8'h0f
`define RST_SYNC_HOLD      8'hca
`define RATE_LOW_INPUTS    4'h0
`define RATE_HIGH_INPUTS   4'h3

// ****************************************************************
// field positions
// ****************************************************************
`define BIT_SOFT_RESET     7
`define BIT_NOMINAL_RATE_FIELD_RANGE     5
`define BIT_LOCK_PIN       4
`define BIT_AUTO_FSYNC     7
`define BIT_ALARM_TIMEOUT  6
`define BIT_OSC_EDGE       5
`define BIT_MANUAL_HOLD    4
`define BIT_FSYNC_EN       3
`define BIT_RATE_FAMILY    2
`define BIT_REVERTIVE      0
`define MASK_VALID_LOW     8'hbf
`define MASK_VALID_HIGH    8'h01
`define MASK_RESET_LOCK    8'hb7
`define MASK_FORCE_REF     8'h0f
`define MASK_SYNC_HOLD     8'hfd

// ****************************************************************
// codes
// ****************************************************************
`define STATE_AUTO         3'h0
`define STATE_LOCKED       3'h4
`define FORCE_AUTO_A       4'h0
`define FORCE_AUTO_B       4'hf
`define FORCE_IN5_ALT      4'h6
`define FORCE_IN8          4'h8
`define FORCE_IN9          4'h9
`define NUM_INPUTS         9
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// *** rtl/refsel_config.v ***
/*
 * Reference-select and master-configuration register bank, AXI4-Lite slave.
 * Assumes single clock core_clk, synchronous active-high rst, and that the
 * DPLL, monitors and priority logic outside consume the decoded controls.
 */
`timescale 1ns/1ps
`include "refsel_consts.vh"

module refsel_config
(
    input  wire        core_clk,
    input  wire        rst,
    // axi4-lite slave
    input  wire [9:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [9:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // device status from the DPLL core
    input  wire        rate_family_pin,
    input  wire [2:0]  dpll_state,
    input  wire        ref_changed,
    input  wire        locked_to_fsync_src,
    input  wire        three_pin_sync_mode,
    input  wire [8:0]  monitor_valid,
    // decoded controls
    output reg         core_reset,
    output reg  [8:0]  ref_eligible,
    output reg         nominal_rate_field_range_detect_enable,
    output reg         lock_indicator,
    output reg         lock_indicator_oe,
    output reg  [2:0]  forced_state,
    output reg         state_forced,
    output reg  [8:0]  forced_ref_onehot,
    output reg         revertive_select,
    output reg         frame_sync_active,
    output reg         phase_alarm_timeout,
    output reg         oscillator_edge_select,
    output reg         manual_holdover,
    output reg  [35:0] nominal_rate_field
);

    // ****************************************************************
    // register state
    // ****************************************************************
    reg  [7:0]  valid_low_q;
    reg  [7:0]  valid_high_q;
    reg  [7:0]  reset_lock_q;
    reg  [7:0]  force_ref_q;
    reg  [7:0]  sync_hold_q;
    reg  [35:0] rate_q;
    reg         rate_pin_q;
    reg  [9:0]  aw_q;
    reg  [31:0] wd_q;
    reg  [3:0]  ws_q;
    reg         aw_have_q;
    reg         w_have_q;

    wire        soft_rst  = reset_lock_q[`BIT_SOFT_RESET];
    wire        any_rst   = rst | soft_rst;
    wire        do_write  = aw_have_q & w_have_q & ~s_axi_bvalid;
    wire        wr_lane0  = do_write & ws_q[0];
    wire [8:0]  valid_ctl = {valid_high_q[0], valid_low_q[7], 1'b0, valid_low_q[5:0]};
    wire [3:0]  force_code = force_ref_q[3:0];
    // a one-cycle rst would otherwise load the capture of the cycle before
    wire        pin_default = rst ? rate_family_pin : rate_pin_q;
    // software write to the enable in the same cycle wins over this clear
    wire        fsync_clear = ref_changed & three_pin_sync_mode & sync_hold_q[`BIT_AUTO_FSYNC];

    // ****************************************************************
    // address decode; unaligned or unmapped words answer with an error
    // ****************************************************************
    wire        wr_in_map     = (aw_q[1:0] == 2'h0)
                                && (aw_q >= `ADDR_VALID_LOW)
                                && (aw_q <= `ADDR_RATE2);
    wire        rd_in_map     = (s_axi_araddr[1:0] == 2'h0)
                                && (s_axi_araddr >= `ADDR_VALID_LOW)
                                && (s_axi_araddr <= `ADDR_RATE2);
    wire        wr_valid_low  = wr_lane0 & (aw_q == `ADDR_VALID_LOW);
    wire        wr_valid_high = wr_lane0 & (aw_q == `ADDR_VALID_HIGH);
    wire        wr_reset_lock = wr_lane0 & (aw_q == `ADDR_RESET_LOCK);
    wire        wr_force_ref  = wr_lane0 & (aw_q == `ADDR_FORCE_REF);
    wire        wr_sync_hold  = wr_lane0 & (aw_q == `ADDR_SYNC_HOLD);

    // ****************************************************************
    // pin default capture: only the hardware reset samples the pin
    // ****************************************************************
    always @(posedge core_clk)
    begin
        if (rst)
            rate_pin_q <= rate_family_pin;
    end

    // ****************************************************************
    // write channel: accept address and data in either order
    // ****************************************************************
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            aw_q          <= 10'h000;
            wd_q          <= 32'h00000000;
            ws_q          <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
        end
        else
        begin
            // ready pulses once per beat; a captured beat blocks the next until written
            s_axi_awready <= ~aw_have_q & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready  <= ~w_have_q & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid & s_axi_awready)
            begin
                aw_have_q <= 1'b1;
                aw_q      <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready)
            begin
                w_have_q <= 1'b1;
                wd_q     <= s_axi_wdata;
                ws_q     <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_in_map ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (s_axi_bvalid & s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // configuration registers; soft reset clears all but itself
    // ****************************************************************
    always @(posedge core_clk)
    begin
        if (any_rst)
        begin
            valid_low_q  <= `RST_VALID_LOW;
            valid_high_q <= `RST_VALID_HIGH;
            force_ref_q  <= `RST_FORCE_REF;
            sync_hold_q  <= (`RST_SYNC_HOLD & ~(8'h01 << `BIT_RATE_FAMILY))
                            | ({7'h00, pin_default} << `BIT_RATE_FAMILY);
        end
        else
        begin
            if (wr_valid_low)
                valid_low_q <= (wd_q[7:0] & `MASK_VALID_LOW)
                               | (`RST_VALID_LOW & ~`MASK_VALID_LOW);
            if (wr_valid_high)
                valid_high_q <= (wd_q[7:0] & `MASK_VALID_HIGH)
                                | (`RST_VALID_HIGH & ~`MASK_VALID_HIGH);
            if (wr_force_ref)
                force_ref_q <= wd_q[7:0] & `MASK_FORCE_REF;
            if (wr_sync_hold)
                sync_hold_q <= (wd_q[7:0] & `MASK_SYNC_HOLD)
                               | (`RST_SYNC_HOLD & ~`MASK_SYNC_HOLD);
            else if (fsync_clear)
                sync_hold_q[`BIT_FSYNC_EN] <= 1'b0;
        end
    end

    // ****************************************************************
    // reset and lock register: its soft reset bit clears only by rst or software
    // ****************************************************************
    always @(posedge core_clk)
    begin
        if (rst)
            reset_lock_q <= `RST_RESET_LOCK;
        else if (wr_reset_lock)
            reset_lock_q <= wd_q[7:0] & `MASK_RESET_LOCK;
        else if (soft_rst)
            reset_lock_q <= `RST_RESET_LOCK | (8'h01 << `BIT_SOFT_RESET);
    end

    // ****************************************************************
    // nominal rate fields, one nibble per input
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < `NUM_INPUTS; gi = gi + 1)
        begin : g_rate
            // word that holds this input's nibble, kept at address width
            wire [9:0] word_addr = (gi < 4) ? `ADDR_RATE0
                                 : (gi < 8) ? `ADDR_RATE1 : `ADDR_RATE2;

            always @(posedge core_clk)
            begin
                if (any_rst)
                    rate_q[gi*4 +: 4] <= (gi < 4) ? `RATE_LOW_INPUTS
                                                  : `RATE_HIGH_INPUTS;
                else if (do_write && ws_q[gi % 4] && aw_q == word_addr)
                    rate_q[gi*4 +: 4] <= wd_q[(gi % 4)*8 +: 4];
            end
        end
    endgenerate

    // ****************************************************************
    // read channel
    // ****************************************************************
    reg [31:0] rd_mux;
    always @*
    begin
        rd_mux = 32'h00000000;
        case (s_axi_araddr)
            `ADDR_VALID_LOW:  rd_mux = {24'h000000, valid_low_q};
            `ADDR_VALID_HIGH: rd_mux = {24'h000000, valid_high_q};
            `ADDR_RESET_LOCK: rd_mux = {24'h000000, reset_lock_q};
            `ADDR_FORCE_REF:  rd_mux = {24'h000000, force_ref_q};
            `ADDR_SYNC_HOLD:  rd_mux = {24'h000000, sync_hold_q};
            `ADDR_STATUS:     rd_mux = {16'h0000, 4'h0, dpll_state, monitor_valid};
            `ADDR_RATE0:      rd_mux = {4'h0, rate_q[15:12], 4'h0, rate_q[11:8],
                                        4'h0, rate_q[7:4], 4'h0, rate_q[3:0]};
            `ADDR_RATE1:      rd_mux = {4'h0, rate_q[31:28], 4'h0, rate_q[27:24],
                                        4'h0, rate_q[23:20], 4'h0, rate_q[19:16]};
            `ADDR_RATE2:      rd_mux = {28'h0000000, rate_q[35:32]};
            default:          rd_mux = 32'h00000000;
        endcase
    end

    always @(posedge core_clk)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
            if (s_axi_arvalid & s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                // data is latched at the address handshake, so a later address cannot tear it
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= rd_in_map ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (s_axi_rvalid & s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // decoded controls to the DPLL core
    // ****************************************************************
    reg [8:0] force_dec;
    always @*
    begin
        force_dec = 9'h000;
        case (force_code)
            4'h1, 4'h2, 4'h3, 4'h4, 4'h5: force_dec = 9'h001 << (force_code - 4'h1);
            `FORCE_IN5_ALT:               force_dec = 9'h010; // code 6 also selects input 5
            `FORCE_IN8:                   force_dec = 9'h080;
            `FORCE_IN9:                   force_dec = 9'h100;
            default:                      force_dec = 9'h000;
        endcase
    end

    always @(posedge core_clk)
    begin
        if (rst)
        begin
            core_reset               <= 1'b1;
            ref_eligible             <= 9'h000;
            nominal_rate_field_range_detect_enable <= 1'b1;
            lock_indicator           <= 1'b0;
            lock_indicator_oe        <= 1'b0;
            forced_state             <= `STATE_AUTO;
            state_forced             <= 1'b0;
            forced_ref_onehot        <= 9'h000;
            revertive_select         <= 1'b0;
            frame_sync_active        <= 1'b0;
            phase_alarm_timeout      <= 1'b1;
            oscillator_edge_select   <= 1'b0;
            manual_holdover          <= 1'b0;
            nominal_rate_field       <= 36'h000000000;
        end
        else
        begin
            core_reset   <= soft_rst;
            // status bits stay untouched; only eligibility is masked
            ref_eligible <= monitor_valid & valid_ctl;
            nominal_rate_field_range_detect_enable <= reset_lock_q[`BIT_NOMINAL_RATE_FIELD_RANGE];
            lock_indicator    <= reset_lock_q[`BIT_LOCK_PIN]
                                 & (dpll_state == `STATE_LOCKED);
            lock_indicator_oe <= reset_lock_q[`BIT_LOCK_PIN];
            forced_state <= reset_lock_q[2:0];
            state_forced <= (reset_lock_q[2:0] != `STATE_AUTO);
            // core gives this input top priority and never switches away
            forced_ref_onehot <= force_dec;
            revertive_select  <= sync_hold_q[`BIT_REVERTIVE];
            frame_sync_active <= sync_hold_q[`BIT_FSYNC_EN]
                                 & (three_pin_sync_mode | ~sync_hold_q[`BIT_AUTO_FSYNC]
                                    | locked_to_fsync_src);
            phase_alarm_timeout    <= sync_hold_q[`BIT_ALARM_TIMEOUT];
            oscillator_edge_select <= sync_hold_q[`BIT_OSC_EDGE];
            manual_holdover        <= sync_hold_q[`BIT_MANUAL_HOLD];
            nominal_rate_field     <= rate_q;
        end
    end

endmodule // refsel_config

// *** test/refsel_config_chk.sv ***
/*
 * Concurrent checks on the ports of the reference-select register bank.
 * Assumes one clock core_clk and a synchronous active-high rst.
 */
`timescale 1ns/1ps
module refsel_config_chk
(
    input wire        core_clk,
    input wire        rst,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_bvalid,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [2:0]  dpll_state,
    input wire [8:0]  monitor_valid,
    input wire        core_reset,
    input wire [8:0]  ref_eligible,
    input wire        nominal_rate_field_range_detect_enable,
    input wire        lock_indicator,
    input wire        lock_indicator_oe,
    input wire [2:0]  forced_state,
    input wire        state_forced,
    input wire [8:0]  forced_ref_onehot
);
    // ********
    // controls
    // ********
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    eligible_subset_a:
        assert property ((ref_eligible & ~$past(monitor_valid)) == 9'h000)
        else $error("input eligible without monitor validity");
    eligible_gap_a:
        assert property (ref_eligible[6] == 1'b0) else $error("input 7 eligible");
    lock_gate_a:
        assert property (lock_indicator |-> lock_indicator_oe && $past(dpll_state) == 3'h4)
        else $error("lock pin high without enable and lock");
    lock_follow_a:
        assert property (lock_indicator_oe && $past(dpll_state) == 3'h4 |-> lock_indicator)
        else $error("lock pin low while enabled and locked");
    state_flag_a:
        assert property (state_forced == (forced_state != 3'h0))
        else $error("state force flag disagrees with code");
    force_onehot_a:
        assert property ($onehot0(forced_ref_onehot) && !forced_ref_onehot[6])
        else $error("bad forced reference decode");
    soft_reset_defaults_a:
        assert property (core_reset && $past(core_reset) |-> !state_forced
            && forced_ref_onehot == 9'h000 && !lock_indicator_oe && nominal_rate_field_range_detect_enable)
        else $error("fields not at default during reset");

    // ********
    // bus
    // ********
    read_answer_a:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    write_answer_a:
        assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
        else $error("write response late");
    err_read_zero_a:
        assert property (s_axi_rvalid && s_axi_rresp != 2'h0 |-> s_axi_rdata == 32'h0)
        else $error("error read returned data");
    read_retire_a:
        assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data not retired");
endmodule // refsel_config_chk

// *** test/refsel_config_tb.sv ***
/*
 * Self-checking bench for the reference-select register bank over AXI4-Lite.
 * Assumes the design and its constants header are compiled alongside.
 */
`timescale 1ns/1ps
module refsel_config_tb;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic [9:0]  s_axi_awaddr = 10'h000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'h1;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic [9:0]  s_axi_araddr = 10'h000;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic        rate_family_pin = 1'b1;
    logic [2:0]  dpll_state = 3'h0;
    logic        ref_changed = 1'b0;
    logic        locked_to_fsync_src = 1'b0;
    logic        three_pin_sync_mode = 1'b0;
    logic [8:0]  monitor_valid = 9'h000;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0]   s_axi_bresp, s_axi_rresp;
    wire [31:0]  s_axi_rdata;
    wire         core_reset, nominal_rate_field_range_detect_enable, lock_indicator, lock_indicator_oe;
    wire         state_forced, revertive_select, frame_sync_active, phase_alarm_timeout;
    wire         oscillator_edge_select, manual_holdover;
    wire [8:0]   ref_eligible, forced_ref_onehot;
    wire [2:0]   forced_state;
    wire [35:0]  nominal_rate_field;
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    logic [8:0]  v, m;
    int          num_errors = 0, num_checks = 0, i;
    // {written value, fsync source lock, fsync/alarm/edge/holdover/revertive}
    logic [13:0] sync_cases [6] = '{{8'h08, 1'b0, 5'h10}, {8'h88, 1'b0, 5'h00},
        {8'h88, 1'b1, 5'h10}, {8'h80, 1'b1, 5'h00}, {8'h71, 1'b0, 5'h0f}, {8'h00, 1'b1, 5'h00}};

    always #2.5 core_clk = ~core_clk;

    refsel_config i_dut (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rate_family_pin, .dpll_state,
        .ref_changed, .locked_to_fsync_src, .three_pin_sync_mode, .monitor_valid, .core_reset,
        .ref_eligible, .nominal_rate_field_range_detect_enable, .lock_indicator, .lock_indicator_oe,
        .forced_state, .state_forced, .forced_ref_onehot, .revertive_select,
        .frame_sync_active, .phase_alarm_timeout, .oscillator_edge_select, .manual_holdover,
        .nominal_rate_field);

    // ********
    // helpers
    // ********
    task automatic report_and_stop;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic timeout;
        num_errors++;
        $display("[ERR] %0t no bus answer", $time);
        report_and_stop;
    endtask

    // outputs follow one cycle after a change; two edges leave margin
    task automatic settle;
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0,
                      input logic [3:0] s = 4'h1);
        int n;
        @(posedge core_clk);
        bq.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid && n < 64);
        s_axi_bready <= 1'b0;
        if (!s_axi_bvalid) timeout;
    endtask

    task automatic rd(input logic [9:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
        int n;
        @(posedge core_clk);
        rq.push_back({r, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid && n < 64);
        s_axi_rready <= 1'b0;
        if (!s_axi_rvalid) timeout;
    endtask

    task automatic pulse_change;
        @(posedge core_clk);
        ref_changed <= 1'b1;
        @(posedge core_clk);
        ref_changed <= 1'b0;
        settle;
    endtask

    function automatic logic [8:0] onehot_of(input int c);
        case (c)
            1, 2, 3, 4, 5: return 9'h001 << (c - 1);
            6: return 9'h010;
            8: return 9'h080;
            9: return 9'h100;
            default: return 9'h000;
        endcase
    endfunction

    // bus answers are compared in arrival order against the queued notes
    always @(posedge core_clk)
    begin
        if (s_axi_rvalid && s_axi_rready && rq.size() > 0)
            chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (s_axi_bvalid && s_axi_bready && bq.size() > 0)
            chk(s_axi_bresp, bq.pop_front());
    end

    // ********
    // sequence
    // ********
    initial
    begin
        i = $urandom(11308);
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        rate_family_pin <= 1'b0;
        rd(10'h0c0, 32'hbf);
        rd(10'h0c4, 32'h01);
        rd(10'h0c8, 32'h20);
        rd(10'h0cc, 32'h0f);
        rd(10'h0d0, 32'hce);
        rd(10'h0d8, 32'h0);
        rd(10'h0dc, 32'h03030303);
        rd(10'h0e0, 32'h03);
        rd(10'h100, 32'h0, 2'h2);
        wr(10'h100, 32'hff, 2'h2);
        settle;
        chk({nominal_rate_field, nominal_rate_field_range_detect_enable}, {36'h333330000, 1'b1});
        repeat (4)
        begin
            v = $urandom | 9'h040;
            m = $urandom | 9'h040;
            monitor_valid <= m;
            wr(10'h0c0, {24'h0, v[7:0]});
            wr(10'h0c4, {31'h0, v[8]});
            settle;
            chk(ref_eligible, m & {v[8], v[7], 1'b0, v[5:0]});
            rd(10'h0c0, v[7:0] & 8'hbf);
            rd(10'h0c4, v[8]);
            rd(10'h0d4, {dpll_state, m});
        end
        for (i = 0; i < 8; i++)
        begin
            dpll_state <= i[2:0];
            wr(10'h0c8, 32'h30 | i);
            settle;
            chk({lock_indicator, lock_indicator_oe, state_forced, forced_state},
                {i == 4, 1'b1, i != 0, i[2:0]});
        end
        dpll_state <= 3'h4;
        wr(10'h0c8, 32'h24);
        settle;
        chk({lock_indicator, lock_indicator_oe}, 2'b00);
        for (i = 0; i < 16; i++)
        begin
            wr(10'h0cc, i);
            settle;
            chk(forced_ref_onehot, onehot_of(i));
        end
        wr(10'h0cc, 32'h3, 2'h0, 4'he);
        rd(10'h0cc, 32'h0f);
        foreach (sync_cases[k])
        begin
            locked_to_fsync_src <= sync_cases[k][5];
            wr(10'h0d0, sync_cases[k][13:6]);
            settle;
            chk({frame_sync_active, phase_alarm_timeout, oscillator_edge_select,
                 manual_holdover, revertive_select},
                sync_cases[k][4:0]);
            rd(10'h0d0, sync_cases[k][13:6] | 8'h02);
        end
        // three-pin mode: auto bit decides whether a reference change drops the enable
        three_pin_sync_mode <= 1'b1;
        locked_to_fsync_src <= 1'b0;
        wr(10'h0d0, 32'h88);
        settle;
        chk(frame_sync_active, 1'b1);
        pulse_change;
        chk(frame_sync_active, 1'b0);
        rd(10'h0d0, 32'h82);
        wr(10'h0d0, 32'h08);
        pulse_change;
        rd(10'h0d0, 32'h0a);
        // byte lanes 0 and 2 only: inputs 5 and 7 take new codes, 6 and 8 keep theirs
        wr(10'h0dc, 32'h0c0b0a09, 2'h0, 4'h5);
        settle;
        chk(nominal_rate_field, 36'h33b390000);
        rd(10'h0dc, 32'h030b0309);
        wr(10'h0c8, 32'h87);
        settle;
        chk({core_reset, state_forced, forced_ref_onehot}, {1'b1, 1'b0, 9'h0});
        rd(10'h0c8, 32'ha0);
        rd(10'h0d0, 32'hce);
        rd(10'h0dc, 32'h03030303);
        wr(10'h0c8, 32'h20);
        settle;
        chk(core_reset, 1'b0);
        report_and_stop;
    end
endmodule // refsel_config_tb

bind refsel_config refsel_config_chk i_chk (.core_clk, .rst, .s_axi_awvalid, .s_axi_awready,
    .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .dpll_state, .monitor_valid, .core_reset, .ref_eligible,
    .nominal_rate_field_range_detect_enable, .lock_indicator, .lock_indicator_oe, .forced_state,
    .state_forced, .forced_ref_onehot);
